// ==== design/otg_control_and_rise_irq_regs.sv ====
// OTG function control register and rising-edge interrupt enable register with event detection
//
// Summary of operation
// - The OTG control register sits at 0Ah with a set alias at 0Bh and a clear alias at 0Ch, all three readable.
// - Bit 7 picks the power-valid source: 0 the internal comparator, 1 the external indicator pin.
// - Bit 6 set pulls the open-drain power switch pin low; clear leaves it undriven.
// - Bit 5 asks for the internal 5 V drive, and the link may leave it clear when bit 6 is set.
// - Bit 4 set charges bus power through a resistor for pulse session request; clear stops charging.
// - Discharge lasts as long as bit 3 is 1, and the link writes it back to 0 to stop.
// - Bit 2 connects the minus line pull-down and resets to 1.
// - Bit 1 connects the plus line pull-down and resets to 1.
// - A 0-to-1 change of a status source raises an interrupt and a receive-command only when enabled.
// - All rising-edge enables are set after reset.
// - Enable bits: 3 session end, 2 session valid, 1 power valid, 0 detach; bits 7 to 4 reserved.
// - The rise-enable register sits at 0Dh with set alias 0Eh and clear alias 0Fh, all readable.
`timescale 1ns/1ps
`include "otg_regs_map.svh"
module otg_control_and_rise_irq_regs (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire otg_regs_pkg::reg_addr_t reg_addr_i,
    input wire otg_regs_pkg::reg_byte_t reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output otg_regs_pkg::reg_byte_t reg_rdata_o,
    output logic reg_rdata_valid_o,
    input wire logic session_over_indication_i,
    input wire logic session_good_indication_i,
    input wire logic power_good_indication_i,
    input wire logic external_power_valid_i,
    input wire logic detach_indication_i,
    output logic external_power_valid_select_o,
    output logic power_switch_out_n_o,
    output logic power_switch_oe_o,
    output logic internal_power_drive_enable_o,
    output logic power_charge_enable_o,
    output logic power_discharge_enable_o,
    output logic minus_line_pulldown_enable_o,
    output logic plus_line_pulldown_enable_o,
    output otg_regs_pkg::source_vec_t irq_source_status_o,
    output otg_regs_pkg::source_vec_t rise_event_o,
    output logic rxcmd_request_o
);
    import otg_regs_pkg::*;

    reg_byte_t otg_func_reg;
    reg_byte_t otg_func_next;
    reg_byte_t rise_en_reg;
    reg_byte_t rise_en_next;
    reg_byte_t rdata_reg;
    logic rdata_valid_reg;
    source_vec_t rise_event_reg;
    logic rxcmd_reg;
    logic otg_hit;
    logic rise_hit;
    alias_t otg_alias;
    alias_t rise_alias;
    logic [4:0] raw_vec;
    logic [4:0] sync_level;
    logic [4:0] sync_prev;
    source_vec_t src_level;
    source_vec_t src_prev;
    source_vec_t rise_now;

    function automatic logic in_bank(input reg_addr_t addr, input reg_addr_t base);
        in_bank = (addr >= base) && (addr <= (base + `ALIAS_SPAN));
    endfunction

    function automatic alias_t alias_of(input reg_addr_t addr, input reg_addr_t base);
        reg_addr_t diff;
        diff = addr - base;
        alias_of = diff[1:0];
    endfunction

    // Write, set or clear depending on alias
    function automatic reg_byte_t apply_write(input reg_byte_t cur, input reg_byte_t wd, input alias_t kind);
        case (kind)
            `ALIAS_WRITE: apply_write = wd;
            `ALIAS_SET: apply_write = cur | wd;
            `ALIAS_CLEAR: apply_write = cur & ~wd;
            default: apply_write = cur;
        endcase
    endfunction

    assign otg_hit = in_bank(reg_addr_i, `OTG_FUNC_BASE);
    assign rise_hit = in_bank(reg_addr_i, `RISE_EN_BASE);
    assign otg_alias = alias_of(reg_addr_i, `OTG_FUNC_BASE);
    assign rise_alias = alias_of(reg_addr_i, `RISE_EN_BASE);

    always_comb begin
        otg_func_next = otg_func_reg;
        rise_en_next = rise_en_reg;
        if (reg_write_i && otg_hit) begin
            otg_func_next = apply_write(otg_func_reg, reg_wdata_i, otg_alias);
        end
        if (reg_write_i && rise_hit) begin
            rise_en_next = apply_write(rise_en_reg, reg_wdata_i, rise_alias);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            otg_func_reg <= `OTG_FUNC_RESET;
        end else begin
            otg_func_reg <= otg_func_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rise_en_reg <= `RISE_EN_RESET;
        end else begin
            rise_en_reg <= rise_en_next;
        end
    end

    // Read returns the value held before any same-cycle write
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_reg <= `UNMAPPED_READ;
            rdata_valid_reg <= 1'b0;
        end else begin
            rdata_valid_reg <= reg_read_i;
            if (reg_read_i) begin
                if (otg_hit) begin
                    rdata_reg <= otg_func_reg;
                end else if (rise_hit) begin
                    rdata_reg <= rise_en_reg;
                end else begin
                    rdata_reg <= `UNMAPPED_READ;
                end
            end
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign reg_rdata_valid_o = rdata_valid_reg;

    assign external_power_valid_select_o = otg_func_reg[`EXT_VALID_SEL_BIT];
    assign power_switch_out_n_o = 1'b0;
    assign power_switch_oe_o = otg_func_reg[`EXT_SWITCH_BIT];
    assign internal_power_drive_enable_o = otg_func_reg[`INT_DRIVE_BIT];
    assign power_charge_enable_o = otg_func_reg[`CHARGE_BIT];
    assign power_discharge_enable_o = otg_func_reg[`DISCHARGE_BIT];
    assign minus_line_pulldown_enable_o = otg_func_reg[`MINUS_PD_BIT];
    assign plus_line_pulldown_enable_o = otg_func_reg[`PLUS_PD_BIT];

    // Bit 4 carries the external indicator pin
    assign raw_vec = {external_power_valid_i, session_over_indication_i, session_good_indication_i,
                      power_good_indication_i, detach_indication_i};

    signal_sync #(
        .WIDTH(5)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .async_i(raw_vec),
        .level_o(sync_level),
        .prev_o(sync_prev)
    );

    always_comb begin
        src_level = sync_level[3:0];
        src_prev = sync_prev[3:0];
        if (otg_func_reg[`EXT_VALID_SEL_BIT]) begin
            src_level[`POWER_GOOD_BIT] = sync_level[4];
            src_prev[`POWER_GOOD_BIT] = sync_prev[4];
        end
    end

    assign rise_now = src_level & ~src_prev & rise_en_reg[3:0];

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rise_event_reg <= 4'h0;
            rxcmd_reg <= 1'b0;
        end else begin
            rise_event_reg <= rise_now;
            rxcmd_reg <= |rise_now;
        end
    end

    assign rise_event_o = rise_event_reg;
    assign rxcmd_request_o = rxcmd_reg;
    assign irq_source_status_o = src_level;

    property p_base_write;
        @(posedge ref_clk_i) disable iff (reset_i)
        reg_write_i && (reg_addr_i == `OTG_FUNC_BASE) |=> otg_func_reg == $past(reg_wdata_i);
    endproperty
    a_base_write: assert property (p_base_write) else $error("control base write not stored");

    property p_set_alias;
        @(posedge ref_clk_i) disable iff (reset_i)
        reg_write_i && (reg_addr_i == 6'h0b) |=> otg_func_reg == ($past(otg_func_reg) | $past(reg_wdata_i));
    endproperty
    a_set_alias: assert property (p_set_alias) else $error("control set alias wrong");

    property p_clear_alias;
        @(posedge ref_clk_i) disable iff (reset_i)
        reg_write_i && (reg_addr_i == 6'h0c) |=> otg_func_reg == ($past(otg_func_reg) & ~$past(reg_wdata_i));
    endproperty
    a_clear_alias: assert property (p_clear_alias) else $error("control clear alias wrong");

    property p_rise_set;
        @(posedge ref_clk_i) disable iff (reset_i)
        reg_write_i && (reg_addr_i == 6'h0e) |=> rise_en_reg == ($past(rise_en_reg) | $past(reg_wdata_i));
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("enable set alias wrong");

    property p_read_back;
        @(posedge ref_clk_i) disable iff (reset_i)
        reg_read_i && (reg_addr_i >= 6'h0a) && (reg_addr_i <= 6'h0c)
        |=> reg_rdata_valid_o && (reg_rdata_o == $past(otg_func_reg));
    endproperty
    a_read_back: assert property (p_read_back) else $error("control read data wrong");

    property p_reset_values;
        @(posedge ref_clk_i)
        reset_i |=> (otg_func_reg == 8'h06) && (rise_en_reg == 8'h1f) && minus_line_pulldown_enable_o;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

    property p_switch_follows;
        @(posedge ref_clk_i) disable iff (reset_i)
        reg_write_i && (reg_addr_i == 6'h0a) |=> power_switch_oe_o == $past(reg_wdata_i[6]) && !power_switch_out_n_o;
    endproperty
    a_switch_follows: assert property (p_switch_follows) else $error("power switch enable wrong");

    property p_discharge_holds;
        @(posedge ref_clk_i) disable iff (reset_i)
        power_discharge_enable_o && !reg_write_i |=> power_discharge_enable_o;
    endproperty
    a_discharge_holds: assert property (p_discharge_holds) else $error("discharge dropped");

    property p_masked_event;
        @(posedge ref_clk_i) disable iff (reset_i)
        rise_event_o[3] |-> $past(rise_en_reg[3]) && rxcmd_request_o;
    endproperty
    a_masked_event: assert property (p_masked_event) else $error("masked event reported");

    property p_external_select;
        @(posedge ref_clk_i) disable iff (reset_i)
        otg_func_reg[7] && rise_en_reg[1] && !$past(sync_level[4]) && sync_level[4] && !reg_write_i
        |=> rise_event_o[1];
    endproperty
    a_external_select: assert property (p_external_select) else $error("external indicator edge lost");
endmodule // otg_control_and_rise_irq_regs

// ==== common/otg_regs_map.svh ====
// Register addresses, field positions, reset values and alias codes for the OTG control and rise-enable bank
`ifndef OTG_REGS_MAP_SVH
`define OTG_REGS_MAP_SVH

// Base (write) addresses; set alias is base+1, clear alias base+2
`define OTG_FUNC_BASE 6'h0a
`define RISE_EN_BASE 6'h0d
`define ALIAS_SPAN 6'h02

// Offset from base selects the kind of write
`define ALIAS_WRITE 2'h0
`define ALIAS_SET 2'h1
`define ALIAS_CLEAR 2'h2

// Reset values
`define OTG_FUNC_RESET 8'h06
`define RISE_EN_RESET 8'h1f

// Read data for an address outside this bank
`define UNMAPPED_READ 8'h00

// Field positions of otg_function_control
`define EXT_VALID_SEL_BIT 7
`define EXT_SWITCH_BIT 6
`define INT_DRIVE_BIT 5
`define CHARGE_BIT 4
`define DISCHARGE_BIT 3
`define MINUS_PD_BIT 2
`define PLUS_PD_BIT 1

// Field positions of rising_edge_irq_enable and of the event vector
`define SESSION_OVER_BIT 3
`define SESSION_GOOD_BIT 2
`define POWER_GOOD_BIT 1
`define DETACH_BIT 0

`endif

// ==== common/otg_regs_pkg.sv ====
// Types shared by the OTG control and rise-enable register bank
package otg_regs_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [5:0] reg_addr_t;
    typedef logic [3:0] source_vec_t;
    typedef logic [1:0] alias_t;
endpackage

// ==== design/signal_sync.sv ====
// Two-flop synchroniser with a delayed copy for edge detection
`timescale 1ns/1ps
module signal_sync #(
    parameter int WIDTH = 5
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] prev_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] prev_reg;

    // First stage is read only by the second
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            level_reg <= '0;
        end else begin
            meta_reg <= async_i;
            level_reg <= meta_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level_reg;
        end
    end

    assign level_o = level_reg;
    assign prev_o = prev_reg;
endmodule // signal_sync

// ==== test/link_model.sv ====
// Link-side model driving the register strobe port
`timescale 1ns/1ps
module link_model (
    input wire logic ref_clk_i,
    output otg_regs_pkg::reg_addr_t reg_addr_o,
    output otg_regs_pkg::reg_byte_t reg_wdata_o,
    output logic reg_write_o,
    output logic reg_read_o,
    input wire otg_regs_pkg::reg_byte_t reg_rdata_i,
    input wire logic reg_rdata_valid_i,
    input wire logic rxcmd_request_i
);
    import otg_regs_pkg::*;
    initial begin
        reg_addr_o = 6'h3f;
        reg_wdata_o = 8'h00;
        reg_write_o = 1'b0;
        reg_read_o = 1'b0;
    end
    task automatic wr(input reg_addr_t addr, input reg_byte_t data);
        reg_byte_t d;
        d = data;
        if (addr >= 6'h0a && addr <= 6'h0c) d[0] = 1'b0;
        @(posedge ref_clk_i);
        reg_addr_o <= addr;
        reg_wdata_o <= d;
        reg_write_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_write_o <= 1'b0;
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~d;
        #1;
    endtask
    task automatic rd(input reg_addr_t addr, output reg_byte_t data, output logic ok);
        @(posedge ref_clk_i);
        reg_addr_o <= addr;
        reg_read_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_read_o <= 1'b0;
        reg_addr_o <= ~addr;
        #1;
        data = reg_rdata_i;
        ok = reg_rdata_valid_i;
    endtask
    task automatic end_discharge(output logic ok);
        ok = 1'b0;
        repeat (16) begin
            @(posedge ref_clk_i);
            #1;
            if (rxcmd_request_i === 1'b1) ok = 1'b1;
        end
        wr(6'h0c, 8'h08);
    endtask
endmodule // link_model

// ==== test/otg_control_and_rise_irq_regs_tb.sv ====
// Self-checking bench for the OTG control and rise-enable bank
`timescale 1ns/1ps
module otg_control_and_rise_irq_regs_tb;
    import otg_regs_pkg::*;
    logic ref_clk_i, reset_i, reg_write, reg_read, rvalid, sel, oe, out_n, drv, chg, dis, mpd, ppd, rx;
    reg_addr_t reg_addr;
    reg_byte_t reg_wdata, rdata;
    source_vec_t status, rise;
    logic [4:0] src;
    int bad_count = 0;
    int n_tests = 0;
    wire [7:0] ctl = {sel, oe, drv, chg, dis, mpd, ppd, 1'b0};
    link_model u_link (.ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_write_o(reg_write), .reg_read_o(reg_read), .reg_rdata_i(rdata),
        .reg_rdata_valid_i(rvalid), .rxcmd_request_i(rx));
    otg_control_and_rise_irq_regs u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_rdata_o(rdata),
        .reg_rdata_valid_o(rvalid), .session_over_indication_i(src[3]), .session_good_indication_i(src[2]),
        .power_good_indication_i(src[1]), .external_power_valid_i(src[4]), .detach_indication_i(src[0]),
        .external_power_valid_select_o(sel), .power_switch_out_n_o(out_n), .power_switch_oe_o(oe),
        .internal_power_drive_enable_o(drv), .power_charge_enable_o(chg), .power_discharge_enable_o(dis),
        .minus_line_pulldown_enable_o(mpd), .plus_line_pulldown_enable_o(ppd), .irq_source_status_o(status),
        .rise_event_o(rise), .rxcmd_request_o(rx));
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    task automatic rd_chk(input reg_addr_t a, input reg_byte_t exp);
        reg_byte_t d;
        logic ok;
        u_link.rd(a, d, ok);
        check("read valid", 8'h01, {7'h00, ok});
        check("read data", exp, d);
    endtask
    task automatic pulse_src(input int i, input source_vec_t exp);
        int n;
        source_vec_t seen;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            seen = 4'h0;
            @(posedge ref_clk_i);
            src[i] <= (ph == 0);
            repeat (10) begin
                @(posedge ref_clk_i);
                #1;
                seen = seen | rise;
                n = n + (rx === 1'b1);
            end
            check("rise event", {4'h0, (ph == 0) ? exp : 4'h0}, {4'h0, seen});
            check("rxcmd count", ((ph == 0) && (exp != 0)) ? 8'h01 : 8'h00, 8'(n));
        end
    endtask
    task automatic t_reset();
        rd_chk(6'h0a, 8'h06);
        rd_chk(6'h0d, 8'h1f);
        check("control pins", 8'h06, ctl);
        $display("reset test done");
    endtask
    task automatic t_alias();
        reg_addr_t b;
        for (int r = 0; r < 2; r++) begin
            b = r ? 6'h0d : 6'h0a;
            u_link.wr(b, 8'ha4);
            for (int k = 0; k < 3; k++) rd_chk(b + 6'(k), 8'ha4);
            u_link.wr(b + 6'h01, 8'h12);
            rd_chk(b + 6'h02, 8'hb6);
            u_link.wr(b + 6'h02, 8'h84);
            rd_chk(b + 6'h01, 8'h32);
        end
        check("control pins", 8'h32, ctl);
        $display("alias test done");
    endtask
    task automatic t_ctrl();
        for (int b = 7; b >= 1; b--) begin
            u_link.wr(6'h0a, 8'h01 << b);
            check("control pins", 8'h01 << b, ctl);
            check("switch level", 8'h00, {7'h00, out_n});
        end
        $display("control test done");
    endtask
    task automatic t_unmapped();
        u_link.wr(6'h0a, 8'h06);
        u_link.wr(6'h09, 8'hff);
        u_link.wr(6'h10, 8'hff);
        rd_chk(6'h10, 8'h00);
        rd_chk(6'h0a, 8'h06);
        rd_chk(6'h0d, 8'h32);
        $display("unmapped test done");
    endtask
    task automatic t_events();
        source_vec_t en;
        for (int p = 0; p < 2; p++) begin
            en = p ? 4'ha : 4'h5;
            u_link.wr(6'h0d, {4'h0, en});
            for (int i = 0; i < 4; i++) pulse_src(i, en & (4'h1 << i));
        end
        u_link.wr(6'h0d, 8'h0f);
        u_link.wr(6'h0b, 8'h80);
        pulse_src(4, 4'h2);
        pulse_src(1, 4'h0);
        u_link.wr(6'h0c, 8'h80);
        $display("event test done");
    endtask
    task automatic t_discharge();
        logic ok;
        u_link.wr(6'h0b, 8'h08);
        check("discharge on", 8'h01, {7'h00, dis});
        @(posedge ref_clk_i);
        src[3] <= 1'b1;
        u_link.end_discharge(ok);
        check("session end report", 8'h01, {7'h00, ok});
        check("discharge off", 8'h00, {7'h00, dis});
        check("status", 8'h08, {4'h0, status});
        u_link.wr(6'h0b, 8'h10);
        check("charge on", 8'h01, {7'h00, chg});
        u_link.wr(6'h0c, 8'h10);
        check("charge off", 8'h00, {7'h00, chg});
        $display("discharge test done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
    initial begin
        reset_i = 1'b1;
        src = 5'h00;
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_alias();
        t_unmapped();
        t_events();
        t_discharge();
        t_ctrl();
        stop_test();
    end
endmodule // otg_control_and_rise_irq_regs_tb
